// ---- design/wat_pkg.sv ----
// Constants, encodings and helpers for the watchdog with address trap
package wat_pkg;
	localparam int unsigned   DIV_WIDTH      = 23;
	localparam logic [4:0]    FAST_TAP_TOP   = 5'h16;
	localparam logic [4:0]    SLOW_TAP_TOP   = 5'h0e;
	localparam logic [7:0]    CODE_CLEAR     = 8'h4e;
	localparam logic [7:0]    CODE_DISABLE   = 8'hb1;
	localparam logic [7:0]    CODE_TRAP_LOAD = 8'hd2;
	localparam int unsigned   CFG_FAULT_BIT  = 0;
	localparam int unsigned   CFG_TIME_LSB   = 1;
	localparam int unsigned   CFG_EN_BIT     = 3;
	localparam int unsigned   CFG_TRAP_ACTION_SELECT_BIT  = 6;
	localparam int unsigned   CFG_RAM_TRAP_SELECT_BIT   = 7;
	localparam logic [1:0]    TIME_RST       = 2'h0;
	localparam logic          FAULT_RST      = 1'b1;
	localparam logic          EN_RST         = 1'b1;
	localparam logic          RAM_TRAP_SELECT_RST       = 1'b1;
	localparam logic          TRAP_ACTION_SELECT_RST      = 1'b1;
	localparam int unsigned   RESET_EXTRA    = 24;
	localparam int unsigned   RESET_NVM      = 1024;
	localparam int unsigned   RESET_CLOCKS   = RESET_EXTRA + RESET_NVM;
	localparam int unsigned   RESET_CNT_W    = 11;

	typedef enum logic [1:0] {
		WAT_CODE_NONE    = 2'b00,
		WAT_CODE_CLEAR   = 2'b01,
		WAT_CODE_DISABLE = 2'b10,
		WAT_CODE_TRAP    = 2'b11
	} wat_code_t;

	// Divider bit whose rising edge clocks the binary counter
	function automatic logic [4:0] wat_tap(input logic [1:0] det_time, input logic slow);
		logic [4:0] top;
		top = slow ? SLOW_TAP_TOP : FAST_TAP_TOP;
		return 5'(top - {2'h0, det_time, 1'b0});
	endfunction

	function automatic wat_code_t wat_decode(input logic [7:0] code);
		wat_code_t c;
		c = WAT_CODE_NONE;
		if (code == CODE_CLEAR) begin
			c = WAT_CODE_CLEAR;
		end else if (code == CODE_DISABLE) begin
			c = WAT_CODE_DISABLE;
		end else if (code == CODE_TRAP_LOAD) begin
			c = WAT_CODE_TRAP;
		end
		return c;
	endfunction
endpackage

// ---- design/wat_link_if.sv ----
// Signals shared between the watchdog core, its divider and the trap checker
interface wat_link_if;
	logic [1:0] det_time;
	logic       slow_mode;
	logic       run;
	logic       stage_tick;
	logic       ram_trap_active;
	logic       trap_to_reset;
	logic       trap_int;
	logic       trap_rst;

	modport core (output det_time, output slow_mode, output run, input stage_tick,
		output ram_trap_active, output trap_to_reset, input trap_int, input trap_rst);
	modport div  (input det_time, input slow_mode, input run, output stage_tick);
	modport trap (input ram_trap_active, input trap_to_reset, output trap_int,
		output trap_rst);
endinterface

// ---- design/wat_divider.sv ----
// Divider, held in stop and idle and stepped by slow_tick_i in slow mode, that supplies the binary counter clock enable
module wat_divider
	import wat_pkg::*;
#(
	parameter int unsigned WIDTH = DIV_WIDTH
) (
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic slow_tick_i,
	wat_link_if.div   link
);
	import wat_pkg::*;

	logic [WIDTH-1:0] div_q;
	logic [WIDTH-1:0] div_d;
	logic             tap_q;
	logic             tap_d;
	logic             step;

	always_comb begin
		step  = link.run && (!link.slow_mode || slow_tick_i);
		div_d = step ? WIDTH'(div_q + 1'b1) : div_q;
		tap_d = div_q[wat_tap(link.det_time, link.slow_mode)];
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			div_q <= '0;
			tap_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tap_q <= tap_d;
		end
	end

	assign link.stage_tick = tap_d && !tap_q;
endmodule

// ---- design/wat_trap_check.sv ----
// Address trap detection on instruction fetch
module wat_trap_check (
	input  wire logic fetch_i,
	input  wire logic fetch_ram_i,
	input  wire logic fetch_sfr_dbr_i,
	wat_link_if.trap  link
);
	logic hit;

	always_comb begin
		hit = fetch_i && (fetch_sfr_dbr_i || (fetch_ram_i && link.ram_trap_active));
	end

	assign link.trap_int = hit && !link.trap_to_reset;
	assign link.trap_rst = hit && link.trap_to_reset;
endmodule

// ---- design/wat_top.sv ----
// Watchdog supervisor core with code register, fault actions and address trap settings
module wat_top
	import wat_pkg::*;
#(
	parameter int unsigned RESET_LEN = RESET_CLOCKS
) (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       cfg_wr_i,
	input  wire logic [7:0] cfg_data_i,
	input  wire logic       code_wr_i,
	input  wire logic [7:0] code_data_i,
	input  wire logic       stop_i,
	input  wire logic       idle_i,
	input  wire logic       slow_mode_i,
	input  wire logic       slow_tick_i,
	input  wire logic       nmi_ack_i,
	input  wire logic       sw_int_ack_i,
	input  wire logic       nmi_return_i,
	input  wire logic       fetch_i,
	input  wire logic       fetch_ram_i,
	input  wire logic       fetch_sfr_dbr_i,
	output logic [7:0]      cfg_rdata_o,
	output logic            active_o,
	output logic [1:0]      count_o,
	output logic            nmi_req_o,
	output logic            wdt_reset_o,
	output logic            nvm_reset_o,
	output logic            hf_osc_start_o,
	output logic            trap_irq_o,
	output logic            trap_reset_o
);
	import wat_pkg::*;

	wat_link_if link ();

	wat_divider u_div (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.slow_tick_i (slow_tick_i),
		.link        (link.div)
	);

	wat_trap_check u_trap (
		.fetch_i         (fetch_i),
		.fetch_ram_i     (fetch_ram_i),
		.fetch_sfr_dbr_i (fetch_sfr_dbr_i),
		.link            (link.trap)
	);

	// Configuration register state
	logic       fault_q;
	logic       fault_d;
	logic       lock_q;
	logic       lock_d;
	logic       en_q;
	logic       en_d;
	logic [1:0] time_q;
	logic [1:0] time_d;
	logic       ram_trap_select_q;
	logic       ram_trap_select_d;
	logic       ram_trap_select_act_q;
	logic       ram_trap_select_act_d;
	logic       trap_action_select_q;
	logic       trap_action_select_d;
	wat_code_t  code;

	always_comb begin
		code       = code_wr_i ? wat_decode(code_data_i) : WAT_CODE_NONE;
		fault_d    = fault_q;
		lock_d     = lock_q;
		en_d       = en_q;
		time_d     = time_q;
		ram_trap_select_d     = ram_trap_select_q;
		trap_action_select_d    = trap_action_select_q;
		ram_trap_select_act_d = ram_trap_select_act_q;
		if (cfg_wr_i) begin
			if (!lock_q) begin
				fault_d = cfg_data_i[CFG_FAULT_BIT];
			end
			lock_d  = 1'b1;
			en_d    = cfg_data_i[CFG_EN_BIT];
			time_d  = cfg_data_i[CFG_TIME_LSB +: 2];
			ram_trap_select_d  = cfg_data_i[CFG_RAM_TRAP_SELECT_BIT];
			trap_action_select_d = cfg_data_i[CFG_TRAP_ACTION_SELECT_BIT];
		end
		if (code == WAT_CODE_TRAP) begin
			ram_trap_select_act_d = ram_trap_select_q;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			fault_q    <= FAULT_RST;
			lock_q     <= 1'b0;
			en_q       <= EN_RST;
			time_q     <= TIME_RST;
			ram_trap_select_q     <= RAM_TRAP_SELECT_RST;
			ram_trap_select_act_q <= RAM_TRAP_SELECT_RST;
			trap_action_select_q    <= TRAP_ACTION_SELECT_RST;
		end else begin
			fault_q    <= fault_d;
			lock_q     <= lock_d;
			en_q       <= en_d;
			time_q     <= time_d;
			ram_trap_select_q     <= ram_trap_select_d;
			ram_trap_select_act_q <= ram_trap_select_act_d;
			trap_action_select_q    <= trap_action_select_d;
		end
	end

	assign link.det_time        = time_q;
	assign link.slow_mode       = slow_mode_i;
	assign link.run             = !(stop_i || idle_i);
	assign link.ram_trap_active = ram_trap_select_act_q;
	assign link.trap_to_reset   = trap_action_select_q;

	// Binary counter, enable state and overflow
	logic       active_q;
	logic       active_d;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic       ovf;

	always_comb begin
		active_d = active_q;
		cnt_d    = cnt_q;
		ovf      = 1'b0;
		if (cfg_wr_i && cfg_data_i[CFG_EN_BIT]) begin
			active_d = 1'b1;
		end
		if (active_q && link.run && link.stage_tick) begin
			ovf   = (cnt_q == 2'h3);
			cnt_d = 2'(cnt_q + 2'h1);
		end
		if (code == WAT_CODE_CLEAR) begin
			cnt_d = 2'h0;
			ovf   = 1'b0;
		end else if (code == WAT_CODE_DISABLE && !en_q) begin
			active_d = 1'b0;
			cnt_d    = 2'h0;
			ovf      = 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			active_q <= 1'b1;
			cnt_q    <= 2'h0;
		end else begin
			active_q <= active_d;
			cnt_q    <= cnt_d;
		end
	end

	// Fault actions: interrupt with service hold, or timed reset
	logic                   pend_q;
	logic                   pend_d;
	logic                   serv_q;
	logic                   serv_d;
	logic                   nmi_q;
	logic                   nmi_d;
	logic [RESET_CNT_W-1:0] rcnt_q;
	logic [RESET_CNT_W-1:0] rcnt_d;
	logic                   rst_q;
	logic                   rst_d;
	logic                   osc_q;
	logic                   osc_d;
	logic                   tirq_q;
	logic                   tirq_d;
	logic                   trst_q;
	logic                   trst_d;

	always_comb begin
		pend_d = pend_q;
		serv_d = serv_q;
		if (nmi_ack_i) begin
			pend_d = 1'b0;
		end
		if (ovf && !fault_q) begin
			pend_d = 1'b1;
		end
		if (nmi_return_i) begin
			serv_d = 1'b0;
		end
		if (nmi_ack_i || sw_int_ack_i) begin
			serv_d = 1'b1;
		end
		nmi_d  = pend_d && !serv_d;
		rcnt_d = (rcnt_q != '0) ? RESET_CNT_W'(rcnt_q - 1'b1) : rcnt_q;
		if (ovf && fault_q) begin
			rcnt_d = RESET_CNT_W'(RESET_LEN);
		end
		rst_d  = (rcnt_d != '0);
		osc_d  = ovf && fault_q && slow_mode_i;
		tirq_d = link.trap_int;
		trst_d = link.trap_rst;
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pend_q <= 1'b0;
			serv_q <= 1'b0;
			nmi_q  <= 1'b0;
			rcnt_q <= '0;
			rst_q  <= 1'b0;
			osc_q  <= 1'b0;
			tirq_q <= 1'b0;
			trst_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
			serv_q <= serv_d;
			nmi_q  <= nmi_d;
			rcnt_q <= rcnt_d;
			rst_q  <= rst_d;
			osc_q  <= osc_d;
			tirq_q <= tirq_d;
			trst_q <= trst_d;
		end
	end

	// Readback of configuration
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	always_comb begin
		rdata_d                        = 8'h00;
		rdata_d[CFG_FAULT_BIT]         = fault_q;
		rdata_d[CFG_TIME_LSB +: 2]     = time_q;
		rdata_d[CFG_EN_BIT]            = en_q;
		rdata_d[CFG_TRAP_ACTION_SELECT_BIT]         = trap_action_select_q;
		rdata_d[CFG_RAM_TRAP_SELECT_BIT]          = ram_trap_select_q;
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign cfg_rdata_o    = rdata_q;
	assign active_o       = active_q;
	assign count_o        = cnt_q;
	assign nmi_req_o      = nmi_q;
	assign wdt_reset_o    = rst_q;
	assign nvm_reset_o    = rst_q;
	assign hf_osc_start_o = osc_q;
	assign trap_irq_o     = tirq_q;
	assign trap_reset_o   = trst_q;

	// Checks
	property p_select_once;
		@(posedge clock_i) disable iff (rst_i)
		cfg_wr_i && lock_q |=> $stable(fault_q);
	endproperty
	a_select_once: assert property (p_select_once) else $error("fault select changed twice");

	property p_on_after_reset;
		@(posedge clock_i) disable iff (rst_i)
		$fell(rst_i) |-> active_q && en_q && fault_q;
	endproperty
	a_on_after_reset: assert property (p_on_after_reset) else $error("not enabled after reset");

	property p_reset_action;
		@(posedge clock_i) disable iff (rst_i)
		ovf && fault_q |=> ##1 wdt_reset_o && nvm_reset_o;
	endproperty
	a_reset_action: assert property (p_reset_action) else $error("overflow gave no reset");

	property p_irq_action;
		@(posedge clock_i) disable iff (rst_i)
		ovf && !fault_q && !nmi_ack_i |=> pend_q && !wdt_reset_o;
	endproperty
	a_irq_action: assert property (p_irq_action) else $error("overflow gave no interrupt");

	property p_hold_in_stop;
		@(posedge clock_i) disable iff (rst_i)
		(stop_i || idle_i) && !code_wr_i |=> cnt_q == $past(cnt_q);
	endproperty
	a_hold_in_stop: assert property (p_hold_in_stop) else $error("counted while stopped");

	property p_clear_code;
		@(posedge clock_i) disable iff (rst_i)
		code == WAT_CODE_CLEAR |=> cnt_q == 2'h0 && (!pend_q || $past(pend_q));
	endproperty
	a_clear_code: assert property (p_clear_code) else $error("clear code ignored");

	property p_disable_refused;
		@(posedge clock_i) disable iff (rst_i)
		code == WAT_CODE_DISABLE && en_q && active_q |=> active_q;
	endproperty
	a_disable_refused: assert property (p_disable_refused) else $error("disabled while enabled");

	property p_disable_clears;
		@(posedge clock_i) disable iff (rst_i)
		code == WAT_CODE_DISABLE && !en_q && !cfg_wr_i |=> !active_q && cnt_q == 2'h0;
	endproperty
	a_disable_clears: assert property (p_disable_clears) else $error("disable failed");

	property p_reset_length;
		@(posedge clock_i) disable iff (rst_i)
		$rose(wdt_reset_o) |-> wdt_reset_o [*8];
	endproperty
	a_reset_length: assert property (p_reset_length) else $error("reset pulse too short");

	property p_nmi_held;
		@(posedge clock_i) disable iff (rst_i)
		serv_q && !nmi_return_i |=> !nmi_req_o;
	endproperty
	a_nmi_held: assert property (p_nmi_held) else $error("nmi during service");

	property p_trap_load;
		@(posedge clock_i) disable iff (rst_i)
		code == WAT_CODE_TRAP |=> ram_trap_select_act_q == $past(ram_trap_select_q);
	endproperty
	a_trap_load: assert property (p_trap_load) else $error("trap setting not loaded");

	property p_unknown_code;
		@(posedge clock_i) disable iff (rst_i)
		code_wr_i && code == WAT_CODE_NONE && !cfg_wr_i |=> $stable(active_q)
			&& $stable(ram_trap_select_act_q);
	endproperty
	a_unknown_code: assert property (p_unknown_code) else $error("unknown code acted");
endmodule

// ---- tb/wat_top_bench.sv ----
// Self-checking bench for the watchdog with address trap
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module wat_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import wat_pkg::*;
	localparam int unsigned RL = 8;
	logic       clock_i         = 1'b0;
	logic       rst_i           = 1'b1;
	logic       cfg_wr_i        = 1'b0;
	logic [7:0] cfg_data_i      = 8'h00;
	logic       code_wr_i       = 1'b0;
	logic [7:0] code_data_i     = 8'h00;
	logic       stop_i          = 1'b0;
	logic       idle_i          = 1'b0;
	logic       slow_mode_i     = 1'b1;
	logic       slow_tick_i     = 1'b1;
	logic [3:0] pl              = 4'h0;
	logic       fetch_ram_i     = 1'b0;
	logic       fetch_sfr_dbr_i = 1'b0;
	logic [7:0] cfg_rdata_o;
	logic       active_o;
	logic [1:0] count_o;
	logic       nmi_req_o;
	logic       wdt_reset_o;
	logic       nvm_reset_o;
	logic       hf_osc_start_o;
	logic       trap_irq_o;
	logic       trap_reset_o;
	int         n_mismatch      = 0;
	int         compares        = 0;
	int         n_hf            = 0;
	int         n_nmi           = 0;

	wat_top #(.RESET_LEN(RL)) i_dut (
		.clock_i(clock_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i), .cfg_data_i(cfg_data_i),
		.code_wr_i(code_wr_i), .code_data_i(code_data_i), .stop_i(stop_i), .idle_i(idle_i),
		.slow_mode_i(slow_mode_i), .slow_tick_i(slow_tick_i), .nmi_ack_i(pl[0]),
		.sw_int_ack_i(pl[1]), .nmi_return_i(pl[2]), .fetch_i(pl[3]),
		.fetch_ram_i(fetch_ram_i), .fetch_sfr_dbr_i(fetch_sfr_dbr_i),
		.cfg_rdata_o(cfg_rdata_o), .active_o(active_o), .count_o(count_o),
		.nmi_req_o(nmi_req_o), .wdt_reset_o(wdt_reset_o), .nvm_reset_o(nvm_reset_o),
		.hf_osc_start_o(hf_osc_start_o), .trap_irq_o(trap_irq_o),
		.trap_reset_o(trap_reset_o)
	);

	always #25 clock_i = ~clock_i;

	always @(posedge clock_i) begin
		if (hf_osc_start_o === 1'b1) n_hf++;
		if (nmi_req_o === 1'b1) n_nmi++;
	end

	function automatic logic [7:0] cfgv(input logic f, input logic [1:0] t, input logic en,
		input logic ao, input logic as);
		return {as, ao, 2'b00, en, t, f};
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic cfg_w(input logic [7:0] v);
		@(posedge clock_i);
		cfg_wr_i <= 1'b1;
		cfg_data_i <= v;
		@(posedge clock_i);
		cfg_wr_i <= 1'b0;
	endtask

	task automatic code_w(input logic [7:0] v);
		@(posedge clock_i);
		code_wr_i <= 1'b1;
		code_data_i <= v;
		@(posedge clock_i);
		code_wr_i <= 1'b0;
	endtask

	task automatic pulse(input logic [3:0] m);
		@(posedge clock_i);
		pl <= m;
		@(posedge clock_i);
		pl <= 4'h0;
		#1;
	endtask

	task automatic do_reset();
		@(posedge clock_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		tick(2);
	endtask

	// Waits for an overflow action, bounded
	task automatic wait_ev(output int n);
		n = 0;
		while (nmi_req_o !== 1'b1 && wdt_reset_o !== 1'b1 && n < 20000) begin
			tick(1);
			n++;
		end
	endtask

	task automatic t_reset();
		do_reset();
		`CHK(cfg_rdata_o, {RAM_TRAP_SELECT_RST, TRAP_ACTION_SELECT_RST, 2'b00, EN_RST, TIME_RST, FAULT_RST})
		`CHK(active_o, 1'b1)
		`CHK(count_o, 2'b00)
		$display("reset values done");
	endtask

	task automatic t_reset_action();
		int n;
		int k;
		cfg_w(cfgv(1'b1, 2'd3, 1'b1, 1'b1, 1'b1));
		code_w(CODE_CLEAR);
		tick(1);
		`CHK(cfg_rdata_o, cfgv(1'b1, 2'd3, 1'b1, 1'b1, 1'b1))
		wait_ev(n);
		`CHK(wdt_reset_o, 1'b1)
		`CHK(nvm_reset_o, 1'b1)
		`CHK(nmi_req_o, 1'b0)
		`CHK(n >= 1536 - 8 && n <= 2048 + 4, 1'b1)
		k = 0;
		while (wdt_reset_o === 1'b1 && k < 100) begin
			tick(1);
			k++;
		end
		`CHK(k, RL)
		`CHK(n_hf, 1)
		$display("reset action done");
	endtask

	task automatic t_nmi();
		int n;
		int p;
		int c;
		do_reset();
		cfg_w(cfgv(1'b0, 2'd3, 1'b1, 1'b1, 1'b1));
		cfg_w(cfgv(1'b1, 2'd3, 1'b1, 1'b1, 1'b1));
		tick(2);
		`CHK(cfg_rdata_o[CFG_FAULT_BIT], 1'b0)
		for (int t = 3; t >= 2; t--) begin
			p = 4 << (15 - 2 * t);
			cfg_w(cfgv(1'b0, 2'(t), 1'b1, 1'b1, 1'b1));
			code_w(CODE_CLEAR);
			wait_ev(n);
			`CHK(nmi_req_o, 1'b1)
			`CHK(wdt_reset_o, 1'b0)
			`CHK(n >= 3 * p / 4 - 8 && n <= p + 4, 1'b1)
			pulse(4'h1);
			`CHK(nmi_req_o, 1'b0)
			pulse(4'h4);
		end
		wait_ev(n);
		`CHK(n >= p - 16 && n <= p, 1'b1)
		pulse(4'h1);
		pulse(4'h4);
		pulse(4'h2);
		c = n_nmi;
		tick(8300);
		`CHK(n_nmi - c, 0)
		pulse(4'h4);
		tick(2);
		`CHK(nmi_req_o, 1'b1)
		pulse(4'h1);
		pulse(4'h4);
		$display("interrupt action done");
	endtask

	task automatic t_codes();
		int c;
		int m;
		do_reset();
		cfg_w(cfgv(1'b0, 2'd3, 1'b1, 1'b1, 1'b1));
		m = n_nmi;
		for (int i = 0; i < 4; i++) begin
			tick(1400);
			code_w(CODE_CLEAR);
			tick(1);
			`CHK(count_o, 2'b00)
		end
		`CHK(n_nmi - m, 0)
		tick(600);
		@(posedge clock_i);
		stop_i <= 1'b1;
		tick(2);
		c = count_o;
		`CHK(c != 0, 1'b1)
		code_w(8'h55);
		tick(2);
		`CHK(count_o, 2'(c))
		`CHK(cfg_rdata_o, cfgv(1'b0, 2'd3, 1'b1, 1'b1, 1'b1))
		code_w(CODE_DISABLE);
		tick(1);
		`CHK(active_o, 1'b1)
		tick(3000);
		@(posedge clock_i);
		stop_i <= 1'b0;
		idle_i <= 1'b1;
		tick(1000);
		`CHK(count_o, 2'(c))
		`CHK(n_nmi - m, 0)
		@(posedge clock_i);
		idle_i <= 1'b0;
		tick(1);
		`CHK(count_o, 2'(c))
		// Held divider phase brings the next step 184 cycles after release
		tick(200);
		`CHK(count_o, 2'(c + 1))
		code_w(CODE_CLEAR);
		cfg_w(cfgv(1'b0, 2'd3, 1'b0, 1'b1, 1'b1));
		code_w(CODE_DISABLE);
		tick(1);
		`CHK(active_o, 1'b0)
		`CHK(count_o, 2'b00)
		tick(3000);
		`CHK(count_o, 2'b00)
		`CHK(n_nmi - m, 0)
		cfg_w(cfgv(1'b0, 2'd3, 1'b1, 1'b1, 1'b1));
		tick(2);
		`CHK(active_o, 1'b1)
		$display("code register done");
	endtask

	task automatic trap_chk(input logic ram, input logic special_function_area, input logic ei, input logic er);
		@(posedge clock_i);
		pl <= 4'h8;
		fetch_ram_i <= ram;
		fetch_sfr_dbr_i <= special_function_area;
		@(posedge clock_i);
		pl <= 4'h0;
		#1;
		`CHK({trap_irq_o, trap_reset_o}, {ei, er})
		tick(1);
		`CHK({trap_irq_o, trap_reset_o}, 2'b00)
	endtask

	task automatic t_trap();
		do_reset();
		trap_chk(1'b0, 1'b1, 1'b0, 1'b1);
		trap_chk(1'b1, 1'b0, 1'b0, 1'b1);
		trap_chk(1'b0, 1'b0, 1'b0, 1'b0);
		cfg_w(cfgv(1'b0, 2'd0, 1'b1, 1'b0, 1'b0));
		tick(2);
		`CHK(cfg_rdata_o, cfgv(1'b0, 2'd0, 1'b1, 1'b0, 1'b0))
		trap_chk(1'b1, 1'b0, 1'b1, 1'b0);
		code_w(CODE_TRAP_LOAD);
		tick(1);
		trap_chk(1'b1, 1'b0, 1'b0, 1'b0);
		trap_chk(1'b0, 1'b1, 1'b1, 1'b0);
		$display("address trap done");
	endtask

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge clock_i);
		n_mismatch++;
		$display("watchdog of the bench expired");
		report_and_stop();
	end

	initial begin
		t_reset();
		t_reset_action();
		t_nmi();
		t_codes();
		t_trap();
		report_and_stop();
	end
endmodule
